// ===== common/apdu_defines.svh
// constants for the record-read command framing block
`ifndef APDU_DEFINES_SVH
`define APDU_DEFINES_SVH

// ==========================================
// command header
`define HDR_LAST_IDX      2'h3
`define CLA_INTERINDUSTRY 8'h00
`define INS_READ_RECORD   8'hB2
`define LE_ZERO           8'h00
`define LE_ZERO_MAX       9'h100

// ==========================================
// parameter two layout
`define P2_SFI_MSB        7
`define P2_SFI_LSB        3
`define P2_MODE_MSB       2
`define P2_MODE_LSB       0
`define P2_MODE_REC_NUM   3'h4
`define SFI_MIN           5'h01
`define SFI_MAX           5'h1E

// ==========================================
// directory record tags
`define TAG_APP_TEMPLATE  8'h61
`define TAG_DIR_DISCR     8'h73

// ==========================================
// status trailers
`define SW_OK             16'h9000
`define SW_WRONG_LENGTH   16'h6700
`define SW_BAD_P1P2       16'h6A86
`define SW_NO_RECORD      16'h6A83
`define SW_INS_UNSUP      16'h6D00
`define SW_CLA_UNSUP      16'h6E00

// ==========================================
// response buffer
`define FIFO_WIDTH        8
`define FIFO_DEPTH        16

`endif

// ===== common/apdu_pkg.sv
// types shared by the record-read framing block
package apdu_pkg;

   // ==========================================
   // sequencer states
   typedef enum logic [2:0]
   {
      ST_HEADER = 3'h0,
      ST_BODY   = 3'h1,
      ST_DECODE = 3'h2,
      ST_FETCH  = 3'h3,
      ST_SW1    = 3'h4,
      ST_SW2    = 3'h5
   } seq_state_type;

   // ==========================================
   // command structure cases
   typedef enum logic [2:0]
   {
      CASE_1   = 3'h0,
      CASE_2   = 3'h1,
      CASE_3   = 3'h2,
      CASE_4   = 3'h3,
      CASE_BAD = 3'h4
   } cmd_case_type;

endpackage

// ===== common/byte_fifo_if.sv
// carrier between the framing sequencer and its response buffer
`timescale 1ns/1ps
`include "apdu_defines.svh"

interface byte_fifo_if;
   logic                     wr_valid;
   logic [`FIFO_WIDTH-1:0]   wr_data;
   logic                     wr_ready;
   logic                     rd_valid;
   logic [`FIFO_WIDTH-1:0]   rd_data;
   logic                     rd_ready;

   modport user
   (
      output wr_valid, wr_data, rd_ready,
      input  wr_ready, rd_valid, rd_data
   );

   modport buffer
   (
      input  wr_valid, wr_data, rd_ready,
      output wr_ready, rd_valid, rd_data
   );
endinterface

// ===== rtl/byte_fifo.sv
// synchronous byte fifo holding record data ahead of the trailer
`timescale 1ns/1ps
`include "apdu_defines.svh"

module byte_fifo
#(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
)
(
   // clock and reset
   input  wire logic   i_clk,
   input  wire logic   i_reset_n,
   // both sides
   byte_fifo_if.buffer fifo
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0]                 wp;
      logic [PW:0]                 rp;
   } fifo_state_type;

   fifo_state_type state_ff;
   fifo_state_type nxt_state;
   logic           full;
   logic           empty;

   // ==========================================
   // flags
   // extra pointer bit tells full from empty without a counter
   assign empty         = (state_ff.wp == state_ff.rp);
   assign full          = (state_ff.wp[PW-1:0] == state_ff.rp[PW-1:0]) &&
                          (state_ff.wp[PW] != state_ff.rp[PW]);
   assign fifo.wr_ready = !full;
   assign fifo.rd_valid = !empty;
   assign fifo.rd_data  = state_ff.mem[state_ff.rp[PW-1:0]];

   // ==========================================
   // next state
   always_comb
   begin
      nxt_state = state_ff;
      if (fifo.wr_valid && !full)
      begin
         nxt_state.mem[state_ff.wp[PW-1:0]] = fifo.wr_data;
         nxt_state.wp                       = state_ff.wp + 1'b1;
      end
      if (fifo.rd_ready && !empty)
      begin
         nxt_state.rp = state_ff.rp + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

endmodule

// ===== rtl/apdu_record_reader.sv
// card-side command parser and response framer for the record-read command
// ==========================================
// Summary of operation
// - command opens with four header bytes
// - length byte, when present, counts following data
// - expected length zero means up to 256
// - response is data then two-byte trailer
// - record read: class 00, B2, expected 00
// - parameter two: identifier high, 100 low
// - identifier range 1 to 30, unique
// - success returns addressed record before trailer
// - file names unique, start with identifier
// - directory records carry tag 61 templates
// - trailer 9000 means success
// - four command structures
`timescale 1ns/1ps
`include "apdu_defines.svh"

module apdu_record_reader
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // command byte stream from transport
   input  wire logic [7:0]  i_cmd_byte,
   input  wire logic        i_cmd_valid,
   input  wire logic        i_cmd_last,
   output logic             o_cmd_ready,
   // record store
   output logic             o_rec_req,
   output logic [4:0]       o_rec_sfi,
   output logic [7:0]       o_rec_number,
   input  wire logic [7:0]  i_rec_byte,
   input  wire logic        i_rec_valid,
   input  wire logic        i_rec_last,
   input  wire logic        i_rec_miss,
   output logic             o_rec_ready,
   input  wire logic [4:0]  i_dir_sfi,
   // response byte stream to transport
   output logic [7:0]       o_rsp_byte,
   output logic             o_rsp_valid,
   output logic             o_rsp_last,
   input  wire logic        i_rsp_ready,
   // status
   output logic             o_dir_record_bad
);

   typedef struct packed
   {
      apdu_pkg::seq_state_type st;
      logic [1:0]              hdr_cnt;
      logic [7:0]              cla;
      logic [7:0]              ins;
      logic [7:0]              p1;
      logic [7:0]              p2;
      logic [7:0]              first_body;
      logic [7:0]              last_body;
      logic [8:0]              body_cnt;
      logic [8:0]              sent;
      logic [8:0]              limit;
      logic [15:0]             sw;
      logic                    rec_done;
      logic                    saw_tag;
      logic                    dir_bad;
   } seq_state_struct_type;

   seq_state_struct_type state_ff;
   seq_state_struct_type nxt_state;
   byte_fifo_if          rsp_buf ();
   apdu_pkg::cmd_case_type cmd_case;
   logic                 cmd_take;
   logic                 rec_take;
   logic                 room;

   // ==========================================
   // helpers
   function automatic apdu_pkg::cmd_case_type classify(input logic [8:0] n,
                                                       input logic [7:0] lc);
      if (n == 9'h000)
         classify = apdu_pkg::CASE_1;
      else if (n == 9'h001)
         classify = apdu_pkg::CASE_2;
      else if (lc != 8'h00 && n == {1'b0, lc} + 9'h001)
         classify = apdu_pkg::CASE_3;
      else if (lc != 8'h00 && n == {1'b0, lc} + 9'h002)
         classify = apdu_pkg::CASE_4;
      else
         classify = apdu_pkg::CASE_BAD;
   endfunction

   function automatic logic sfi_ok(input logic [4:0] sfi);
      sfi_ok = (sfi >= `SFI_MIN) && (sfi <= `SFI_MAX);
   endfunction

   // ==========================================
   // response buffer
   byte_fifo
   #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH)
   )
   u_rsp_fifo
   (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .fifo      (rsp_buf.buffer)
   );

   // ==========================================
   // ports
   assign cmd_case         = classify(state_ff.body_cnt, state_ff.first_body);
   assign o_cmd_ready      = (state_ff.st == apdu_pkg::ST_HEADER) ||
                             (state_ff.st == apdu_pkg::ST_BODY);
   assign cmd_take         = o_cmd_ready && i_cmd_valid;
   assign o_rec_req        = (state_ff.st == apdu_pkg::ST_FETCH) && !state_ff.rec_done;
   // lookup by identifier is scoped to the current application by the store
   assign o_rec_sfi        = state_ff.p2[`P2_SFI_MSB:`P2_SFI_LSB];
   assign o_rec_number     = state_ff.p1;
   assign room             = state_ff.sent < state_ff.limit;
   // bytes beyond the expected length are swallowed, never sent
   assign o_rec_ready      = o_rec_req && (rsp_buf.wr_ready || !room);
   assign rec_take         = o_rec_ready && i_rec_valid;
   assign rsp_buf.wr_valid = o_rec_req && i_rec_valid && room;
   assign rsp_buf.wr_data  = i_rec_byte;
   assign rsp_buf.rd_ready = (state_ff.st == apdu_pkg::ST_FETCH) && i_rsp_ready;
   assign o_dir_record_bad = state_ff.dir_bad;

   // ==========================================
   // response mux: record bytes first, trailer last
   always_comb
   begin
      o_rsp_valid = 1'b0;
      o_rsp_byte  = 8'h00;
      o_rsp_last  = 1'b0;
      unique case (state_ff.st)
         apdu_pkg::ST_FETCH:
         begin
            o_rsp_valid = rsp_buf.rd_valid;
            o_rsp_byte  = rsp_buf.rd_data;
         end
         apdu_pkg::ST_SW1:
         begin
            o_rsp_valid = 1'b1;
            o_rsp_byte  = state_ff.sw[15:8];
         end
         apdu_pkg::ST_SW2:
         begin
            o_rsp_valid = 1'b1;
            o_rsp_byte  = state_ff.sw[7:0];
            o_rsp_last  = 1'b1;
         end
         default:
         begin
            o_rsp_valid = 1'b0;
         end
      endcase
   end

   // ==========================================
   // sequencer
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff.st)
         apdu_pkg::ST_HEADER:
         begin
            if (cmd_take)
            begin
               unique case (state_ff.hdr_cnt)
                  2'h0: nxt_state.cla = i_cmd_byte;
                  2'h1: nxt_state.ins = i_cmd_byte;
                  2'h2: nxt_state.p1  = i_cmd_byte;
                  2'h3: nxt_state.p2  = i_cmd_byte;
               endcase
               nxt_state.hdr_cnt = state_ff.hdr_cnt + 2'h1;
               if (i_cmd_last && state_ff.hdr_cnt != `HDR_LAST_IDX)
               begin
                  nxt_state.sw      = `SW_WRONG_LENGTH;
                  nxt_state.hdr_cnt = 2'h0;
                  nxt_state.st      = apdu_pkg::ST_SW1;
               end
               else if (i_cmd_last)
                  nxt_state.st = apdu_pkg::ST_DECODE;
               else if (state_ff.hdr_cnt == `HDR_LAST_IDX)
                  nxt_state.st = apdu_pkg::ST_BODY;
            end
         end
         apdu_pkg::ST_BODY:
         begin
            if (cmd_take)
            begin
               if (state_ff.body_cnt == 9'h000)
                  nxt_state.first_body = i_cmd_byte;
               nxt_state.last_body = i_cmd_byte;
               // saturate so an overlong body still classifies as bad
               if (state_ff.body_cnt != 9'h1FF)
                  nxt_state.body_cnt = state_ff.body_cnt + 9'h001;
               if (i_cmd_last)
                  nxt_state.st = apdu_pkg::ST_DECODE;
            end
         end
         apdu_pkg::ST_DECODE:
         begin
            nxt_state.st = apdu_pkg::ST_SW1;
            if (cmd_case == apdu_pkg::CASE_BAD)
               nxt_state.sw = `SW_WRONG_LENGTH;
            else if (state_ff.cla != `CLA_INTERINDUSTRY)
               nxt_state.sw = `SW_CLA_UNSUP;
            else if (state_ff.ins != `INS_READ_RECORD)
               nxt_state.sw = `SW_INS_UNSUP;
            else if (cmd_case != apdu_pkg::CASE_2 || state_ff.last_body != `LE_ZERO)
               nxt_state.sw = `SW_WRONG_LENGTH;
            else if (state_ff.p2[`P2_MODE_MSB:`P2_MODE_LSB] != `P2_MODE_REC_NUM ||
                     !sfi_ok(state_ff.p2[`P2_SFI_MSB:`P2_SFI_LSB]))
               nxt_state.sw = `SW_BAD_P1P2;
            else
            begin
               // only Le = 00 gets here, so the full 256 is always granted
               nxt_state.limit = `LE_ZERO_MAX;
               nxt_state.sent  = 9'h000;
               nxt_state.st    = apdu_pkg::ST_FETCH;
            end
         end
         apdu_pkg::ST_FETCH:
         begin
            if (rsp_buf.wr_valid && rsp_buf.wr_ready)
               nxt_state.sent = state_ff.sent + 9'h001;
            if (rec_take && i_rec_byte == `TAG_APP_TEMPLATE)
               nxt_state.saw_tag = 1'b1;
            if (o_rec_req && i_rec_miss)
            begin
               nxt_state.sw       = `SW_NO_RECORD;
               nxt_state.rec_done = 1'b1;
            end
            else if (rec_take && i_rec_last)
            begin
               nxt_state.sw       = `SW_OK;
               nxt_state.rec_done = 1'b1;
               nxt_state.dir_bad  = (o_rec_sfi == i_dir_sfi) && !state_ff.saw_tag &&
                                    (i_rec_byte != `TAG_APP_TEMPLATE);
            end
            // length is never sent; the trailer starts one idle cycle after the last byte leaves the buffer
            if (state_ff.rec_done && !rsp_buf.rd_valid)
               nxt_state.st = apdu_pkg::ST_SW1;
         end
         apdu_pkg::ST_SW1:
         begin
            if (i_rsp_ready)
               nxt_state.st = apdu_pkg::ST_SW2;
         end
         apdu_pkg::ST_SW2:
         begin
            if (i_rsp_ready)
            begin
               nxt_state.st       = apdu_pkg::ST_HEADER;
               nxt_state.hdr_cnt  = 2'h0;
               nxt_state.body_cnt = 9'h000;
               nxt_state.rec_done = 1'b0;
               nxt_state.saw_tag  = 1'b0;
            end
         end
         default:
         begin
            nxt_state.st = apdu_pkg::ST_HEADER;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

endmodule

// ===== testbench/apdu_record_reader_chk.sv
// checker for the record-read framing block
`timescale 1ns/1ps
`include "apdu_defines.svh"

module apdu_record_reader_chk
(
   // clock and reset
   input logic       i_clk,
   input logic       i_reset_n,
   // command stream
   input logic [7:0] i_cmd_byte,
   input logic       i_cmd_valid,
   input logic       i_cmd_last,
   input logic       o_cmd_ready,
   // record store
   input logic       o_rec_req,
   input logic [4:0] o_rec_sfi,
   input logic [7:0] o_rec_number,
   input logic       i_rec_miss,
   // response stream
   input logic [7:0] o_rsp_byte,
   input logic       o_rsp_valid,
   input logic       o_rsp_last,
   input logic       i_rsp_ready
);
   // ==========================================
   // header capture
   logic [3:0] idx_ff;
   logic [7:0] cla_ff;
   logic [7:0] ins_ff;
   logic [7:0] p1_ff;
   logic [7:0] p2_ff;
   logic       take;
   logic       fin;
   logic       rd_ok;
   logic       p2_ok;

   assign take  = i_cmd_valid && o_cmd_ready;
   assign fin   = take && i_cmd_last;
   assign rd_ok = fin && idx_ff == 4'h4 && i_cmd_byte == `LE_ZERO
                  && cla_ff == `CLA_INTERINDUSTRY && ins_ff == `INS_READ_RECORD;
   assign p2_ok = p2_ff[2:0] == `P2_MODE_REC_NUM && p2_ff[7:3] >= `SFI_MIN
                  && p2_ff[7:3] <= `SFI_MAX;

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         idx_ff <= 4'h0;
      else if (take)
         idx_ff <= i_cmd_last ? 4'h0 : idx_ff + 4'(idx_ff != 4'hF);
   end

   // no reset: only read once a header has been collected
   always_ff @(posedge i_clk)
   begin
      if (take && idx_ff == 4'h0)
         cla_ff <= i_cmd_byte;
      if (take && idx_ff == 4'h1)
         ins_ff <= i_cmd_byte;
      if (take && idx_ff == 4'h2)
         p1_ff <= i_cmd_byte;
      if (take && idx_ff == 4'h3)
         p2_ff <= i_cmd_byte;
   end

   // ==========================================
   // properties
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   property p_ready_after_reset;
      $rose(i_reset_n) |-> o_cmd_ready;
   endproperty
   a_ready_after_reset: assert property (p_ready_after_reset)
      else $error("command side not ready after reset");

   property p_no_overlap;
      o_rsp_valid |-> !o_cmd_ready;
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("command taken while response pending");

   property p_rsp_hold;
      o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte) && $stable(o_rsp_last);
   endproperty
   a_rsp_hold: assert property (p_rsp_hold)
      else $error("response byte changed while stalled");

   property p_next_after_trailer;
      o_rsp_valid && o_rsp_last && i_rsp_ready |=> o_cmd_ready;
   endproperty
   a_next_after_trailer: assert property (p_next_after_trailer)
      else $error("not ready after second trailer byte");

   property p_short_header;
      fin && idx_ff < 4'h3 |-> ##1 o_rsp_valid && o_rsp_byte == 8'h67;
   endproperty
   a_short_header: assert property (p_short_header)
      else $error("short header not refused");

   property p_class_refused;
      fin && idx_ff == 4'h4 && cla_ff != `CLA_INTERINDUSTRY |-> ##2 o_rsp_valid && o_rsp_byte == 8'h6E;
   endproperty
   a_class_refused: assert property (p_class_refused)
      else $error("foreign class not refused");

   property p_bad_p2;
      rd_ok && !p2_ok |-> ##2 o_rsp_valid && o_rsp_byte == 8'h6A;
   endproperty
   a_bad_p2: assert property (p_bad_p2)
      else $error("bad reference control not refused");

   property p_fetch;
      rd_ok && p2_ok |-> ##2 o_rec_req && o_rec_sfi == p2_ff[7:3] && o_rec_number == p1_ff;
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("record request wrong");

   property p_miss_status;
      o_rec_req && i_rec_miss |-> ##[1:3] o_rsp_valid && o_rsp_byte == 8'h6A;
   endproperty
   a_miss_status: assert property (p_miss_status)
      else $error("missing record not reported");

   c_fetch: cover property (rd_ok && p2_ok);
   c_miss: cover property (o_rec_req && i_rec_miss);
   c_stall: cover property (o_rsp_valid && !i_rsp_ready);
endmodule

bind apdu_record_reader apdu_record_reader_chk chk (.i_clk, .i_reset_n, .i_cmd_byte,
   .i_cmd_valid, .i_cmd_last, .o_cmd_ready, .o_rec_req, .o_rec_sfi, .o_rec_number,
   .i_rec_miss, .o_rsp_byte, .o_rsp_valid, .o_rsp_last, .i_rsp_ready);

// ===== testbench/record_store_model.sv
// record store model answering record requests
`timescale 1ns/1ps

module record_store_model
#(
   parameter int SEED = 7
)
(
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // request side
   input  wire logic       i_req,
   input  wire logic [7:0] i_number,
   input  wire logic       i_ready,
   // record bytes
   output logic [7:0]      o_byte,
   output logic            o_valid,
   output logic            o_last,
   output logic            o_miss
);
   int         seed = SEED;
   logic [7:0] pos_ff;
   logic       done_ff;
   logic [7:0] cur;

   // first byte is the template tag unless bit 7 of the record number is set (then 70), the rest never look like one
   assign cur    = (pos_ff == 8'h00) ? (i_number[7] ? 8'h70 : 8'h61) : {2'b10, pos_ff[5:0]};
   assign o_byte = o_valid ? cur : ~cur; // idle line shows no stale value
   assign o_last = o_valid && pos_ff == i_number - 8'h01;

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n || !i_req)
      begin
         o_valid <= 1'b0;
         o_miss  <= 1'b0;
         pos_ff  <= 8'h00;
         done_ff <= 1'b0;
      end
      else
      begin
         o_miss <= 1'b0;
         if (!done_ff && i_number == 8'h00)
         begin
            o_miss  <= 1'b1; // record zero is never stored
            done_ff <= 1'b1;
         end
         else if (o_valid && i_ready)
         begin
            pos_ff  <= pos_ff + 8'h01;
            o_valid <= !o_last && ($random(seed) & 3) != 0;
            done_ff <= o_last;
         end
         // an offered byte stays up until it is taken
         else if (!done_ff && !o_valid)
            o_valid <= ($random(seed) & 3) != 0;
      end
   end
endmodule

// ===== testbench/apdu_record_reader_tb.sv
// self-checking bench for the record-read framing block
`timescale 1ns/1ps

module apdu_record_reader_tb;
   typedef logic [7:0] bq_type[$];

   logic       i_clk;
   logic       i_reset_n;
   logic [7:0] i_cmd_byte;
   logic       i_cmd_valid;
   logic       i_cmd_last;
   logic [7:0] i_rec_byte;
   logic       i_rec_valid;
   logic       i_rec_last;
   logic       i_rec_miss;
   logic       i_rsp_ready;
   logic [4:0] i_dir_sfi;
   logic       o_cmd_ready;
   logic       o_rec_req;
   logic [4:0] o_rec_sfi;
   logic [7:0] o_rec_number;
   logic       o_rec_ready;
   logic [7:0] o_rsp_byte;
   logic       o_rsp_valid;
   logic       o_rsp_last;
   logic       o_dir_record_bad;
   int         seed;
   int         fails;
   int         n_compared;
   int         k;
   logic [7:0] num;

   apdu_record_reader dut (.i_clk, .i_reset_n, .i_cmd_byte, .i_cmd_valid, .i_cmd_last,
      .o_cmd_ready, .o_rec_req, .o_rec_sfi, .o_rec_number, .i_rec_byte, .i_rec_valid,
      .i_rec_last, .i_rec_miss, .o_rec_ready, .i_dir_sfi, .o_rsp_byte, .o_rsp_valid,
      .o_rsp_last, .i_rsp_ready, .o_dir_record_bad);

   record_store_model #(.SEED(11)) store (.i_clk, .i_reset_n, .i_req(o_rec_req),
      .i_number(o_rec_number), .i_ready(o_rec_ready), .o_byte(i_rec_byte),
      .o_valid(i_rec_valid), .o_last(i_rec_last), .o_miss(i_rec_miss));

   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // ==========================================
   // helpers
   function automatic bq_type exp_read(input logic [7:0] n);
      bq_type q;
      if (n == 8'h00)
         return '{8'h6A, 8'h83};
      for (int i = 0; i < n; i++)
         q.push_back(i == 0 ? (n[7] ? 8'h70 : 8'h61) : {2'b10, 6'(i)});
      q.push_back(8'h90);
      q.push_back(8'h00);
      return q;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // sends one command, then drains the response under random stalls
   task automatic run_cmd(input bq_type c, input bq_type e);
      int t;
      foreach (c[i])
      begin
         i_cmd_byte  <= c[i];
         i_cmd_valid <= 1'b1;
         i_cmd_last  <= (i == c.size() - 1);
         t = 0;
         do
         begin
            @(posedge i_clk);
            t++;
         end
         while (o_cmd_ready !== 1'b1 && t < 500);
         chk({7'h0, o_cmd_ready}, 8'h01, "command byte taken");
      end
      i_cmd_valid <= 1'b0;
      t = 0;
      while (e.size() > 0 && t < 4000)
      begin
         @(posedge i_clk);
         t++;
         if (o_rsp_valid === 1'b1 && i_rsp_ready === 1'b1)
         begin
            chk(o_rsp_byte, e[0], "response byte");
            chk({7'h0, o_rsp_last}, {7'h0, e.size() == 1}, "last flag");
            void'(e.pop_front());
         end
         i_rsp_ready <= ($random(seed) & 3) != 0;
      end
      chk(8'(e.size()), 8'h00, "response incomplete");
   endtask

   task automatic err(input bq_type c, input logic [15:0] sw);
      run_cmd(c, '{sw[15:8], sw[7:0]});
   endtask

   task automatic wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #3000000;
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      wrap_up();
   end

   // ==========================================
   // main sequence
   initial
   begin
      seed        = 63367;
      fails       = 0;
      n_compared  = 0;
      i_reset_n   = 1'b0;
      i_cmd_byte  = 8'h00;
      i_cmd_valid = 1'b0;
      i_cmd_last  = 1'b0;
      i_rsp_ready = 1'b1;
      i_dir_sfi   = 5'h05;
      repeat (3) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      for (k = 0; k < 12; k++)
      begin
         num = 8'(($random(seed) & 31) + 1);
         run_cmd('{8'h00, 8'hB2, num, {5'(k * 3 % 30 + 1), 3'h4}, 8'h00}, exp_read(num));
      end
      run_cmd('{8'h00, 8'hB2, 8'h7F, 8'h0C, 8'h00}, exp_read(8'h7F));
      run_cmd('{8'h00, 8'hB2, 8'h01, 8'hF4, 8'h00}, exp_read(8'h01));
      run_cmd('{8'h00, 8'hB2, 8'h00, 8'h0C, 8'h00}, exp_read(8'h00));
      $display("test reads done");
      err('{8'h00, 8'hB2, 8'h01}, 16'h6700);
      err('{8'h00, 8'hB2, 8'h01, 8'h0C}, 16'h6700);
      err('{8'h00, 8'hB2, 8'h01, 8'h0C, 8'h01, 8'h55}, 16'h6700);
      err('{8'h00, 8'hB2, 8'h01, 8'h0C, 8'h01, 8'h55, 8'h00}, 16'h6700);
      err('{8'h00, 8'hB2, 8'h01, 8'h0C, 8'h02, 8'h55}, 16'h6700);
      err('{8'h80, 8'hA4, 8'h01, 8'h0C, 8'h00}, 16'h6E00);
      err('{8'h00, 8'hA4, 8'h01, 8'h0C, 8'h00}, 16'h6D00);
      err('{8'h00, 8'hB2, 8'h01, 8'h0C, 8'h05}, 16'h6700);
      err('{8'h00, 8'hB2, 8'h01, 8'h08, 8'h00}, 16'h6A86);
      err('{8'h00, 8'hB2, 8'h01, 8'h04, 8'h00}, 16'h6A86);
      err('{8'h00, 8'hB2, 8'h01, 8'hFC, 8'h00}, 16'h6A86);
      $display("test refusals done");
      run_cmd('{8'h00, 8'hB2, 8'h83, 8'h2C, 8'h00}, exp_read(8'h83));
      chk({7'h0, o_dir_record_bad}, 8'h01, "directory flag set");
      // a refused command ends no record, so the flag stays
      err('{8'h00, 8'hB2, 8'h01, 8'h2C, 8'h05}, 16'h6700);
      chk({7'h0, o_dir_record_bad}, 8'h01, "directory flag held");
      // every record end re-evaluates the flag, other files clear it
      run_cmd('{8'h00, 8'hB2, 8'h81, 8'h34, 8'h00}, exp_read(8'h81));
      chk({7'h0, o_dir_record_bad}, 8'h00, "directory flag other file");
      run_cmd('{8'h00, 8'hB2, 8'h83, 8'h2C, 8'h00}, exp_read(8'h83));
      chk({7'h0, o_dir_record_bad}, 8'h01, "directory flag set again");
      run_cmd('{8'h00, 8'hB2, 8'h03, 8'h2C, 8'h00}, exp_read(8'h03));
      chk({7'h0, o_dir_record_bad}, 8'h00, "directory flag clear");
      $display("test directory done");
      wrap_up();
   end
endmodule
